// ==== bench/serial_rx_model.sv ====
// remote asynchronous receiver that watches the transmit line
// assumes the line is sampled on the system clock and the bit length is given
`timescale 1ns/1ps
module serial_rx_model (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_line,
  input wire logic [8:0] i_bit_clks,
  input wire logic i_nine,
  output logic [8:0] o_data,
  output logic o_stop_ok,
  output logic [7:0] o_frames,
  output logic o_rx_drive
);
  int k;
  // --------------------------------------------------------------
  // frame sampler
  // --------------------------------------------------------------
  // centre sampling: a wrong bit length drifts later samples off their bits
  initial begin
    o_data = '0;
    o_stop_ok = 1'b0;
    o_frames = '0;
    o_rx_drive = 1'b1; // own data line rests at mark
    forever begin
      @(posedge i_clk);
      if (i_reset_n === 1'b1 && i_line === 1'b0) begin
        repeat (i_bit_clks / 2) @(posedge i_clk);
        o_stop_ok = (i_line === 1'b0);
        o_data = '0;
        for (k = 0; k < (i_nine ? 9 : 8); k++) begin
          repeat (i_bit_clks) @(posedge i_clk);
          o_data[k] = i_line;
        end
        repeat (i_bit_clks) @(posedge i_clk);
        o_stop_ok = o_stop_ok && (i_line === 1'b1);
        o_frames = o_frames + 8'h01;
        repeat (i_bit_clks / 2 - 1) @(posedge i_clk);
      end
    end
  end
endmodule

// ==== bench/serial_tx_tb.sv ====
// self-checking bench for the asynchronous serial transmitter
// assumes zero-wait apb answers and a receiver model on the transmit line
`timescale 1ns/1ps
module serial_tx_tb;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err, low;
  logic tx_pin, tx_oe_n, rx_pin, rx_oe_n, tx_irq, rx_drive, tx_line, rx_line;
  logic stop_ok, nine;
  logic [7:0] paddr, frames, seen;
  logic [8:0] got, bit_clks;
  logic [31:0] pwdata, prdata, rd;
  int errors, n_checks, i;
  logic [7:0] modes [3] = '{8'h13, 8'h10, 8'h01};

  // pads: released tx rests on its pull-up, rx resolves both drivers
  assign tx_line = (tx_oe_n === 1'b0) ? tx_pin : 1'b1;
  assign rx_line = (rx_oe_n === 1'b0) ? rx_pin : rx_drive;

  serial_tx i_serial_tx (
    .I_SYS_CLK(clk), .I_RESET_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_RX_PIN(rx_line), .O_TX_PIN(tx_pin),
    .O_TX_PIN_OE_N(tx_oe_n), .O_RX_PIN(rx_pin), .O_RX_PIN_OE_N(rx_oe_n), .O_TX_IRQ(tx_irq)
  );
  serial_rx_model i_serial_rx_model (
    .i_clk(clk), .i_reset_n(rst_n), .i_line(tx_line), .i_bit_clks(bit_clks),
    .i_nine(nine), .o_data(got), .o_stop_ok(stop_ok), .o_frames(frames),
    .o_rx_drive(rx_drive)
  );

  // --------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------
  task automatic stop_test;
    if (errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] act);
    n_checks++;
    if (act !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, act);
    end
  endtask

  // one apb transfer; a spare idle cycle keeps drives one per time step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rd = prdata;
    err = pslverr;
    if (pready !== 1'b1) begin
      errors++;
      stop_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // waits for the receiver to finish the next frame, bounded
  task automatic next_frame(input logic [8:0] exp);
    int k;
    seen = frames;
    for (k = 0; k < 4000 && frames === seen; k++) @(posedge clk);
    if (frames === seen) begin
      errors++;
      stop_test();
    end
    chk("char", {23'h0, exp}, {23'h0, got});
    chk("stop", 32'h1, {31'h0, stop_ok});
  endtask

  // --------------------------------------------------------------
  // clock and sequence
  // --------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    errors = 0;
    n_checks = 0;
    nine = 1'b0;
    bit_clks = 9'h008;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("idle tx", 32'h1, {31'h0, tx_pin});
    apb(1'b0, serial_tx_pkg::PIN_ADDR, '0);
    chk("pin reg", 32'h13, rd);
    apb(1'b0, 8'h20, '0);
    chk("unmapped", 32'h1, {31'h0, err});
    apb(1'b1, serial_tx_pkg::BAUD_ADDR, 32'h7);
    apb(1'b1, serial_tx_pkg::TX_CTRL_ADDR, 32'h11);
    apb(1'b1, serial_tx_pkg::PIN_ADDR, 32'h0);
    apb(1'b0, serial_tx_pkg::FLAG_ADDR, '0);
    chk("flag on", 32'h1, rd);
    chk("tx oe", 32'h0, {31'h0, tx_oe_n});
    chk("rx oe", 32'h1, {31'h0, rx_oe_n});
    apb(1'b1, serial_tx_pkg::PIN_ADDR, 32'h8);
    @(posedge clk);
    chk("rx latch", 32'h1, {31'h0, rx_pin});
    chk("rx forced", 32'h1, {31'h0, rx_oe_n});
    apb(1'b1, serial_tx_pkg::PIN_ADDR, 32'h3);
    // back to back characters: second one waits in the holding buffer
    apb(1'b1, serial_tx_pkg::TX_HOLD_ADDR, 32'ha5);
    apb(1'b0, serial_tx_pkg::FLAG_ADDR, '0);
    chk("flag load", 32'h1, rd);
    apb(1'b1, serial_tx_pkg::TX_HOLD_ADDR, 32'h3c);
    repeat (2) @(posedge clk);
    apb(1'b0, serial_tx_pkg::FLAG_ADDR, '0);
    chk("flag pend", 32'h0, rd);
    apb(1'b1, serial_tx_pkg::FLAG_ADDR, 32'h1);
    apb(1'b0, serial_tx_pkg::FLAG_ADDR, '0);
    chk("flag wr", 32'h0, rd);
    next_frame(9'h0a5);
    next_frame(9'h03c);
    apb(1'b0, serial_tx_pkg::FLAG_ADDR, '0);
    chk("flag back", 32'h1, rd);
    // interrupt request follows flag only while enabled
    apb(1'b1, serial_tx_pkg::IRQ_EN_ADDR, 32'h1);
    @(posedge clk);
    chk("irq on", 32'h1, {31'h0, tx_irq});
    apb(1'b1, serial_tx_pkg::TX_HOLD_ADDR, 32'h0f);
    apb(1'b1, serial_tx_pkg::TX_HOLD_ADDR, 32'h42);
    repeat (4) @(posedge clk);
    chk("irq pend", 32'h0, {31'h0, tx_irq});
    apb(1'b1, serial_tx_pkg::IRQ_EN_ADDR, 32'h0);
    next_frame(9'h00f);
    next_frame(9'h042);
    @(posedge clk);
    chk("irq off", 32'h0, {31'h0, tx_irq});
    // nine-bit frames with both ninth values
    nine = 1'b1;
    apb(1'b1, serial_tx_pkg::TX_CTRL_ADDR, 32'h1d);
    apb(1'b1, serial_tx_pkg::TX_HOLD_ADDR, 32'h55);
    next_frame(9'h155);
    apb(1'b1, serial_tx_pkg::TX_CTRL_ADDR, 32'h15);
    apb(1'b1, serial_tx_pkg::TX_HOLD_ADDR, 32'haa);
    next_frame(9'h0aa);
    // slowest divider value: 256 clocks per bit
    nine = 1'b0;
    bit_clks = 9'h100;
    apb(1'b1, serial_tx_pkg::TX_CTRL_ADDR, 32'h11);
    apb(1'b1, serial_tx_pkg::BAUD_ADDR, 32'hff);
    apb(1'b1, serial_tx_pkg::TX_HOLD_ADDR, 32'h96);
    next_frame(9'h096);
    // slow stop bit is still on the line, let it end first
    repeat (140) @(posedge clk);
    // abort mid frame
    bit_clks = 9'h008;
    apb(1'b1, serial_tx_pkg::BAUD_ADDR, 32'h7);
    apb(1'b1, serial_tx_pkg::TX_HOLD_ADDR, 32'h00);
    repeat (20) @(posedge clk);
    apb(1'b1, serial_tx_pkg::TX_CTRL_ADDR, 32'h10);
    @(posedge clk);
    chk("abort", 32'h1, {31'h0, tx_pin});
    apb(1'b0, serial_tx_pkg::FLAG_ADDR, '0);
    chk("flag off", 32'h0, rd);
    repeat (100) @(posedge clk);
    // any one of the three enables missing keeps the line at mark
    for (i = 0; i < 3; i++) begin
      apb(1'b1, serial_tx_pkg::TX_CTRL_ADDR, {24'h0, modes[i]});
      apb(1'b1, serial_tx_pkg::TX_HOLD_ADDR, 32'h00);
      low = 1'b0;
      repeat (40) @(posedge clk) low = low | (tx_line !== 1'b1);
      chk("no start", 32'h0, {31'h0, low});
    end
    stop_test();
  end
endmodule

// ==== design/serial_tx.sv ====
// asynchronous transmit path with holding buffer, hidden shifter and baud divider
// assumes apb master on I_SYS_CLK; pin pads resolve levels from the enables
`timescale 1ns/1ps
module serial_tx (
  input wire logic I_SYS_CLK,
  input wire logic I_RESET_N,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_RX_PIN,
  output logic O_TX_PIN,
  output logic O_TX_PIN_OE_N,
  output logic O_RX_PIN,
  output logic O_RX_PIN_OE_N,
  output logic O_TX_IRQ
);

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  serial_tx_pkg::tx_ctrl_t ctrl;
  serial_tx_pkg::pin_ctrl_t pins;
  serial_tx_pkg::tx_state_t state;
  logic [7:0] baud_div;
  logic [7:0] baud_cnt;
  logic [8:0] hold_data;
  logic hold_full;
  logic [8:0] shift_data;
  logic [3:0] bit_cnt;
  logic irq_enable;
  logic empty_flag;
  logic [1:0] flag_delay;
  logic run;
  logic bit_tick;
  logic wr;
  logic rd_access;
  logic hold_wr;
  logic load_shift;
  logic next_line;

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] want);
    addr_hit = (a == want);
  endfunction

  assign wr = I_PSEL && I_PENABLE && I_PWRITE;
  assign rd_access = I_PSEL && !I_PENABLE && !I_PWRITE;
  assign hold_wr = wr && addr_hit(I_PADDR, serial_tx_pkg::TX_HOLD_ADDR);
  // transmitter runs only when enabled, asynchronous and port on
  assign run = ctrl.tx_enable && !ctrl.sync_mode && ctrl.port_enable;

  // single-cycle access phase: ready and error registered in setup
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
    end else begin
      O_PREADY <= I_PSEL && !I_PENABLE;
      O_PSLVERR <= I_PSEL && !I_PENABLE && (I_PADDR > serial_tx_pkg::PIN_ADDR);
    end
  end

  // read data captured in setup so it comes from a flop in access
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_PRDATA <= 32'h0000_0000;
    end else if (rd_access) begin
      case (I_PADDR)
        serial_tx_pkg::TX_CTRL_ADDR: O_PRDATA <= {27'h0, ctrl};
        serial_tx_pkg::BAUD_ADDR: O_PRDATA <= {24'h0, baud_div};
        // shifter itself is never readable, only the holding buffer
        serial_tx_pkg::TX_HOLD_ADDR: O_PRDATA <= {23'h0, hold_data};
        serial_tx_pkg::FLAG_ADDR: O_PRDATA <= {31'h0, empty_flag};
        serial_tx_pkg::IRQ_EN_ADDR: O_PRDATA <= {31'h0, irq_enable};
        serial_tx_pkg::PIN_ADDR: O_PRDATA <= {27'h0, I_RX_PIN, pins};
        default: O_PRDATA <= 32'h0000_0000;
      endcase
    end else begin
      O_PRDATA <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      ctrl <= '0;
      baud_div <= serial_tx_pkg::BAUD_RESET;
      irq_enable <= 1'b0;
      pins <= serial_tx_pkg::PIN_DIR_RESET;
    end else if (wr) begin
      case (I_PADDR)
        serial_tx_pkg::TX_CTRL_ADDR: ctrl <= I_PWDATA[4:0];
        serial_tx_pkg::BAUD_ADDR: baud_div <= I_PWDATA[7:0];
        serial_tx_pkg::IRQ_EN_ADDR: irq_enable <= I_PWDATA[0];
        serial_tx_pkg::PIN_ADDR: pins <= I_PWDATA[3:0];
        // flag address is read-only: writes fall here and are dropped
        default: ctrl <= ctrl;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // baud generator
  // ----------------------------------------------------------------
  // 8-bit divider: a bit lasts baud_div+1 system clocks
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      baud_cnt <= 8'h00;
    end else if (state == serial_tx_pkg::ST_IDLE || !run) begin
      baud_cnt <= baud_div;
    end else if (baud_cnt == 8'h00) begin
      baud_cnt <= baud_div;
    end else begin
      baud_cnt <= baud_cnt - 8'h01;
    end
  end
  assign bit_tick = (state != serial_tx_pkg::ST_IDLE) && (baud_cnt == 8'h00);

  // ----------------------------------------------------------------
  // holding buffer and shifter
  // ----------------------------------------------------------------
  // load when idle, or on the tick that ends the stop bit
  assign load_shift = run && hold_full && (state == serial_tx_pkg::ST_IDLE ||
    (state == serial_tx_pkg::ST_STOP && bit_tick));

  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      hold_full <= 1'b0;
      hold_data <= 9'h000;
    end else if (!run) begin
      hold_full <= 1'b0;
    end else if (hold_wr) begin
      // ninth bit from config; software parity may ride there
      hold_data <= {ctrl.ninth_data, I_PWDATA[7:0]};
      hold_full <= 1'b1;
    end else if (load_shift) begin
      hold_full <= 1'b0;
    end
  end

  // frame sequencer
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state <= serial_tx_pkg::ST_IDLE;
      shift_data <= 9'h000;
      bit_cnt <= 4'h0;
    end else if (!run) begin
      state <= serial_tx_pkg::ST_IDLE;
      shift_data <= 9'h000;
      bit_cnt <= 4'h0;
    end else if (load_shift) begin
      shift_data <= hold_data;
      state <= serial_tx_pkg::ST_START;
      bit_cnt <= ctrl.nine_bit ? serial_tx_pkg::DATA_BITS_NINE : serial_tx_pkg::DATA_BITS_EIGHT;
    end else if (bit_tick) begin
      case (state)
        serial_tx_pkg::ST_START: state <= serial_tx_pkg::ST_DATA;
        serial_tx_pkg::ST_DATA: begin
          shift_data <= {1'b0, shift_data[8:1]};
          bit_cnt <= bit_cnt - 4'h1;
          if (bit_cnt == 4'h1) begin
            state <= serial_tx_pkg::ST_STOP;
          end
        end
        serial_tx_pkg::ST_STOP: state <= serial_tx_pkg::ST_IDLE;
        default: state <= serial_tx_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // line and pins
  // ----------------------------------------------------------------
  always_comb begin
    case (state)
      serial_tx_pkg::ST_START: next_line = 1'b0;
      serial_tx_pkg::ST_DATA: next_line = shift_data[0];
      default: next_line = 1'b1;
    endcase
  end

  // port enable overrides direction bits of both pins
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_TX_PIN <= 1'b1;
      O_TX_PIN_OE_N <= 1'b1;
      O_RX_PIN <= 1'b0;
      O_RX_PIN_OE_N <= 1'b1;
    end else begin
      O_TX_PIN <= ctrl.port_enable ? (run ? next_line : 1'b1) : pins.tx_latch;
      O_TX_PIN_OE_N <= ctrl.port_enable ? 1'b0 : pins.tx_dir;
      O_RX_PIN <= pins.rx_latch;
      O_RX_PIN_OE_N <= ctrl.port_enable ? 1'b1 : pins.rx_dir;
    end
  end

  // ----------------------------------------------------------------
  // empty flag and interrupt
  // ----------------------------------------------------------------
  // a write holds the flag for two cycles before it may clear
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      flag_delay <= 2'h0;
    end else if (hold_wr) begin
      flag_delay <= serial_tx_pkg::FLAG_DELAY_CYCLES;
    end else if (flag_delay != 2'h0) begin
      flag_delay <= flag_delay - 2'h1;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      empty_flag <= 1'b0;
    end else if (!ctrl.tx_enable) begin
      empty_flag <= 1'b0;
    end else if (flag_delay == 2'h0 && !hold_wr) begin
      // a write edge never clears the flag itself, even on an overwrite
      empty_flag <= !hold_full;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_TX_IRQ <= 1'b0;
    end else begin
      O_TX_IRQ <= empty_flag && irq_enable;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_stop_end;
    state == serial_tx_pkg::ST_STOP && bit_tick;
  endsequence

  a_idle_mark: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    ctrl.port_enable && state == serial_tx_pkg::ST_IDLE |=> O_TX_PIN)
    else $error("line not mark while idle");
  a_start_space: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    state == serial_tx_pkg::ST_START && run |=> !O_TX_PIN)
    else $error("start bit not space");
  a_bit_hold: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    run && state != serial_tx_pkg::ST_IDLE && baud_cnt != 8'h00 && !load_shift
    |=> $stable(state))
    else $error("bit changed before period end");
  a_not_run: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    !run |=> state == serial_tx_pkg::ST_IDLE)
    else $error("transmitter active while disabled");
  a_tx_output: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    ctrl.port_enable |=> !O_TX_PIN_OE_N)
    else $error("tx pin not driven");
  a_rx_input: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    ctrl.port_enable |=> O_RX_PIN_OE_N)
    else $error("rx pin driven");
  a_chain_load: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    s_stop_end and hold_full and run |=> state == serial_tx_pkg::ST_START)
    else $error("pending char not loaded after stop");
  a_flag_delay: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    hold_wr && empty_flag && ctrl.tx_enable ##1 ctrl.tx_enable |=> empty_flag)
    else $error("flag cleared too early");
  a_irq_gate: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    !irq_enable |=> !O_TX_IRQ)
    else $error("interrupt without enable");

  // shutdown: line back to mark and pending character dropped
  sequence s_stopped;
    ctrl.port_enable && !run;
  endsequence

  a_abort_mark: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    s_stopped |=> O_TX_PIN)
    else $error("line not mark after stop");
  a_drop_pending: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    !run |=> !hold_full)
    else $error("pending char kept while stopped");
  a_hold_load: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    run && hold_full && state == serial_tx_pkg::ST_IDLE && !hold_wr
    |=> state == serial_tx_pkg::ST_START && !hold_full)
    else $error("idle shifter not loaded at once");
  a_lsb_first: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    run && state == serial_tx_pkg::ST_DATA && bit_tick
    |=> shift_data[7:0] == $past(shift_data[8:1]))
    else $error("data not shifted lsb first");
  a_stop_mark: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    run && state == serial_tx_pkg::ST_STOP |=> O_TX_PIN)
    else $error("stop bit not mark");

  // flag bookkeeping: follows the buffer, never written by software
  a_flag_on: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    ctrl.tx_enable && !hold_full && flag_delay == 2'h0 && !hold_wr |=> empty_flag)
    else $error("flag not set while enabled and empty");
  a_flag_off: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    !ctrl.tx_enable |=> !empty_flag)
    else $error("flag set while disabled");
  a_flag_ro: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    wr && addr_hit(I_PADDR, serial_tx_pkg::FLAG_ADDR) && ctrl.tx_enable && flag_delay == 2'h0
    |=> empty_flag == !$past(hold_full))
    else $error("software write moved the flag");
  a_irq_follow: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESET_N)
    irq_enable && empty_flag |=> O_TX_IRQ)
    else $error("enabled interrupt not raised");

endmodule

// ==== shared/serial_tx_pkg.sv ====
// constants and carrier types for the asynchronous serial transmitter
// assumes a single 50 MHz system clock and an apb master on the register side
//
// Notes on behaviour
// - idle line stays at mark level
// - start bit, eight/nine data bits, stop
// - each bit lasts one bit period
// - bit timing from 8-bit baud divider
// - data bits go out lsb first
// - no hardware parity, ninth bit carries it
// - runs only when enabled, async, port on
// - port enable forces tx pin to output
// - port enable forces rx pin to input
// - empty flag set when transmit enabled
// - holding write loads idle shifter at once
// - busy shifter: load after stop bit
// - flag clear only when busy and pending, or transmit disabled
// - flag clears on third clock after write
// - software cannot write the empty flag
// - interrupt request gated by enable bit
// - shifter hidden, loaded only from holding buffer
package serial_tx_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] TX_CTRL_ADDR = 8'h00;
  localparam logic [7:0] BAUD_ADDR = 8'h04;
  localparam logic [7:0] TX_HOLD_ADDR = 8'h08;
  localparam logic [7:0] FLAG_ADDR = 8'h0c;
  localparam logic [7:0] IRQ_EN_ADDR = 8'h10;
  localparam logic [7:0] PIN_ADDR = 8'h14;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int TX_ENABLE_POS = 0;
  localparam int SYNC_MODE_POS = 1;
  localparam int NINE_BIT_POS = 2;
  localparam int NINTH_DATA_POS = 3;
  localparam int PORT_ENABLE_POS = 4;
  localparam int TX_DIR_POS = 0;
  localparam int RX_DIR_POS = 1;
  localparam int TX_LATCH_POS = 2;
  localparam int RX_LATCH_POS = 3;
  localparam int RX_LEVEL_POS = 4;

  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] BAUD_RESET = 8'h00;
  localparam logic [3:0] PIN_DIR_RESET = 4'h3;
  localparam logic [1:0] FLAG_DELAY_CYCLES = 2'h2;
  localparam logic [3:0] DATA_BITS_EIGHT = 4'h8;
  localparam logic [3:0] DATA_BITS_NINE = 4'h9;

  typedef struct packed {
    logic port_enable;
    logic ninth_data;
    logic nine_bit;
    logic sync_mode;
    logic tx_enable;
  } tx_ctrl_t;

  typedef struct packed {
    logic rx_latch;
    logic tx_latch;
    logic rx_dir;
    logic tx_dir;
  } pin_ctrl_t;

  // gray coded along idle -> start -> data -> stop
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_DATA = 2'b11,
    ST_STOP = 2'b10
  } tx_state_t;

endpackage
